// file: core/ppp_pkg.sv
// constants, types and function list for the parallel programming port
package ppp_pkg;
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;

  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  localparam int FLASH_AW = 15;
  localparam int EE_AW    = 11;
  localparam int FWORD_W  = 7;
  localparam int EWORD_W  = 3;
  localparam logic [15:0] ERASE_LAST = 16'h7fff;
  localparam logic [15:0] EE_LAST    = 16'h07ff;
  localparam logic [15:0] FPAGE_END  = 16'h0080;
  localparam logic [15:0] EPAGE_END  = 16'h0008;

  localparam logic [7:0] FUSE_LO_RST  = 8'hff;
  localparam logic [7:0] FUSE_HI_RST  = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST = 8'hff;
  localparam logic [7:0] LOCK_RST     = 8'hff;
  localparam int KEEP_EE_BIT  = 3;
  localparam int LOCK_A_BIT   = 0;
  localparam int LOCK_B_BIT   = 1;
  localparam logic [7:0] BOOT_LOCK_MASK = 8'h3c;

  // identity bytes: arbitrary neutral values
  localparam logic [7:0] SIG_BYTE0 = 8'h5a;
  localparam logic [7:0] SIG_BYTE1 = 8'h01;
  localparam logic [7:0] SIG_BYTE2 = 8'h02;
  localparam logic [7:0] CAL_BYTE  = 8'h80;
  localparam logic [7:0] SIG_LAST  = 8'h02;
  localparam logic [7:0] BLANK     = 8'hff;

  typedef struct packed {
    logic       act_hi;
    logic       act_lo;
    logic       bs_a;
    logic       bs_b;
    logic       load;
    logic       latch;
    logic       wr_b;
    logic       oe_b;
    logic [7:0] data;
  } ppp_pins_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ERASE = 4'h2,
    ST_FPROG = 4'h4,
    ST_EPROG = 4'h8
  } ppp_state_t;
endpackage : ppp_pkg

// file: core/ppp_mem.sv
// simple dual-port memory with registered read data
`timescale 1ns/1ns
module ppp_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          core_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : ppp_mem

// file: core/ppp_port.sv
// parallel programming port: strobe decode, page buffers, sequencer, readback
`timescale 1ns/1ns
module ppp_port
  import ppp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       strobe_action_sel_hi,
  input  wire logic       strobe_action_sel_lo,
  input  wire logic       byte_sel_a,
  input  wire logic       byte_sel_b,
  input  wire logic       load_strobe,
  input  wire logic       buffer_latch_pulse,
  input  wire logic       write_strobe_b,
  input  wire logic       out_enable_b,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            ready_flag
);
  ppp_pins_t pin_raw, pin_s1, pin_s2, pin_s3;

  assign pin_raw = '{act_hi: strobe_action_sel_hi, act_lo: strobe_action_sel_lo,
                     bs_a: byte_sel_a, bs_b: byte_sel_b, load: load_strobe,
                     latch: buffer_latch_pulse, wr_b: write_strobe_b,
                     oe_b: out_enable_b, data: data_in};

  // all pins are asynchronous to core_clk; edges are taken between the second and third stages
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= '{wr_b: 1'b1, oe_b: 1'b1, default: '0};
      pin_s2 <= '{wr_b: 1'b1, oe_b: 1'b1, default: '0};
      pin_s3 <= '{wr_b: 1'b1, oe_b: 1'b1, default: '0};
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  logic       load_rise;
  logic       latch_rise;
  logic       wr_fall;
  logic [1:0] act;

  assign load_rise  = pin_s2.load & ~pin_s3.load;
  assign latch_rise = pin_s2.latch & ~pin_s3.latch;
  assign wr_fall    = ~pin_s2.wr_b & pin_s3.wr_b;
  assign act        = {pin_s2.act_hi, pin_s2.act_lo};

  ppp_state_t  state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [7:0]  cmd, next_cmd;
  logic [7:0]  addr_lo, next_addr_lo;
  logic [7:0]  addr_hi, next_addr_hi;
  logic [7:0]  data_lo, next_data_lo;
  logic [7:0]  data_hi, next_data_hi;
  logic [7:0]  fuse_lo, next_fuse_lo;
  logic [7:0]  fuse_hi, next_fuse_hi;
  logic [7:0]  fuse_ext, next_fuse_ext;
  logic [7:0]  lock, next_lock;
  logic        next_ready;

  logic                f_we, e_we, fb_we, eb_we;
  logic [FLASH_AW-1:0] f_waddr, f_raddr;
  logic [15:0]         f_wdata, f_rdata;
  logic [EE_AW-1:0]    e_waddr, e_raddr;
  logic [7:0]          e_wdata, e_rdata;
  logic [FWORD_W-1:0]  fb_waddr, fb_raddr;
  logic [15:0]         fb_wdata, fb_rdata;
  logic [EWORD_W-1:0]  eb_waddr, eb_raddr;
  logic [7:0]          eb_wdata, eb_rdata;
  logic [FLASH_AW-1:0] f_word;
  logic [EE_AW-1:0]    e_byte;
  logic [15:0]         cnt_m1;
  logic                mode3;

  assign f_word = {addr_hi[FLASH_AW-9:0], addr_lo};
  assign e_byte = {addr_hi[EE_AW-9:0], addr_lo};
  assign cnt_m1 = cnt - 16'h0001;
  assign mode3  = ~lock[LOCK_A_BIT] & ~lock[LOCK_B_BIT];

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_cmd      = cmd;
    next_addr_lo  = addr_lo;
    next_addr_hi  = addr_hi;
    next_data_lo  = data_lo;
    next_data_hi  = data_hi;
    next_fuse_lo  = fuse_lo;
    next_fuse_hi  = fuse_hi;
    next_fuse_ext = fuse_ext;
    next_lock     = lock;
    f_we     = 1'b0;
    f_waddr  = f_word;
    f_wdata  = {BLANK, BLANK};
    e_we     = 1'b0;
    e_waddr  = e_byte;
    e_wdata  = BLANK;
    fb_we    = 1'b0;
    fb_waddr = addr_lo[FWORD_W-1:0];
    fb_wdata = {data_hi, data_lo};
    fb_raddr = cnt[FWORD_W-1:0];
    eb_we    = 1'b0;
    eb_waddr = addr_lo[EWORD_W-1:0];
    eb_wdata = data_lo;
    eb_raddr = cnt[EWORD_W-1:0];
    case (state)
      ST_IDLE: begin
        // registers hold their value until reloaded, so repeat accesses skip reloads
        if (load_rise) begin
          case (act)
            ACT_CMD: begin
              next_cmd = pin_s2.data;
            end
            ACT_ADDR: begin
              if (pin_s2.bs_a) begin
                next_addr_hi = pin_s2.data;
              end else begin
                next_addr_lo = pin_s2.data;
              end
            end
            ACT_DATA: begin
              if (pin_s2.bs_a) begin
                next_data_hi = pin_s2.data;
              end else begin
                next_data_lo = pin_s2.data;
              end
            end
            default: ;
          endcase
        end
        // a no-op command leaves no write selected, so latch and write do nothing
        if (latch_rise && cmd == CMD_WR_FLASH && pin_s2.bs_a) begin
          fb_we = 1'b1;
        end
        if (latch_rise && cmd == CMD_WR_EE) begin
          eb_we = 1'b1;
        end
        if (wr_fall) begin
          next_cnt = 16'h0000;
          case (cmd)
            CMD_ERASE: begin
              next_state = ST_ERASE;
            end
            CMD_WR_FLASH: begin
              next_state = ST_FPROG;
            end
            CMD_WR_EE: begin
              if (!pin_s2.bs_a) begin
                next_state = ST_EPROG;
              end
            end
            CMD_WR_FUSE: begin
              case ({pin_s2.bs_b, pin_s2.bs_a})
                2'h0: next_fuse_lo = data_lo;
                2'h1: next_fuse_hi = data_lo;
                2'h2: next_fuse_ext = data_lo;
                default: ;
              endcase
            end
            CMD_WR_LOCK: begin
              // ones in the data never raise a lock bit back
              next_lock = lock & (data_lo | (mode3 ? BOOT_LOCK_MASK : 8'h00));
            end
            default: ;
          endcase
        end
      end
      ST_ERASE: begin
        f_we    = 1'b1;
        f_waddr = cnt[FLASH_AW-1:0];
        e_waddr = cnt[EE_AW-1:0];
        e_we    = (cnt <= EE_LAST) && fuse_hi[KEEP_EE_BIT];
        next_cnt = cnt + 16'h0001;
        if (cnt == ERASE_LAST) begin
          // lock bits are released only once the whole array is blank
          next_lock  = LOCK_RST;
          next_state = ST_IDLE;
        end
      end
      ST_FPROG: begin
        // buffer read is one cycle behind, so the write trails the read address
        if (cnt != 16'h0000) begin
          f_we     = 1'b1;
          f_waddr  = {f_word[FLASH_AW-1:FWORD_W], cnt_m1[FWORD_W-1:0]};
          f_wdata  = fb_rdata;
          fb_we    = 1'b1;
          fb_waddr = cnt_m1[FWORD_W-1:0];
          fb_wdata = {BLANK, BLANK};
        end
        next_cnt = cnt + 16'h0001;
        if (cnt == FPAGE_END) begin
          next_state = ST_IDLE;
        end
      end
      ST_EPROG: begin
        if (cnt != 16'h0000) begin
          e_we     = 1'b1;
          e_waddr  = {e_byte[EE_AW-1:EWORD_W], cnt_m1[EWORD_W-1:0]};
          e_wdata  = eb_rdata;
          eb_we    = 1'b1;
          eb_waddr = cnt_m1[EWORD_W-1:0];
          eb_wdata = BLANK;
        end
        next_cnt = cnt + 16'h0001;
        if (cnt == EPAGE_END) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // a write strobe during an operation falls outside ST_IDLE and is dropped
    next_ready = (next_state == ST_IDLE);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ST_IDLE;
      cnt        <= 16'h0000;
      cmd        <= CMD_NOP;
      addr_lo    <= 8'h00;
      addr_hi    <= 8'h00;
      data_lo    <= 8'hff;
      data_hi    <= 8'hff;
      fuse_lo    <= FUSE_LO_RST;
      fuse_hi    <= FUSE_HI_RST;
      fuse_ext   <= FUSE_EXT_RST;
      lock       <= LOCK_RST;
      ready_flag <= 1'b1;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      cmd        <= next_cmd;
      addr_lo    <= next_addr_lo;
      addr_hi    <= next_addr_hi;
      data_lo    <= next_data_lo;
      data_hi    <= next_data_hi;
      fuse_lo    <= next_fuse_lo;
      fuse_hi    <= next_fuse_hi;
      fuse_ext   <= next_fuse_ext;
      lock       <= next_lock;
      ready_flag <= next_ready;
    end
  end

  assign f_raddr = f_word;
  assign e_raddr = e_byte;

  // buffers are not reset: their content is undefined until the first latch
  ppp_mem #(.AW(FLASH_AW), .DW(16)) u_flash (
    .core_clk (core_clk),
    .we       (f_we),
    .waddr    (f_waddr),
    .wdata    (f_wdata),
    .raddr    (f_raddr),
    .rdata    (f_rdata)
  );

  ppp_mem #(.AW(EE_AW), .DW(8)) u_eeprom (
    .core_clk (core_clk),
    .we       (e_we),
    .waddr    (e_waddr),
    .wdata    (e_wdata),
    .raddr    (e_raddr),
    .rdata    (e_rdata)
  );

  ppp_mem #(.AW(FWORD_W), .DW(16)) u_fbuf (
    .core_clk (core_clk),
    .we       (fb_we),
    .waddr    (fb_waddr),
    .wdata    (fb_wdata),
    .raddr    (fb_raddr),
    .rdata    (fb_rdata)
  );

  ppp_mem #(.AW(EWORD_W), .DW(8)) u_ebuf (
    .core_clk (core_clk),
    .we       (eb_we),
    .waddr    (eb_waddr),
    .wdata    (eb_wdata),
    .raddr    (eb_raddr),
    .rdata    (eb_rdata)
  );

  logic [7:0] next_data_out;
  logic       next_data_oe;

  always_comb begin
    next_data_oe  = ~pin_s2.oe_b;
    next_data_out = BLANK;
    case (cmd)
      CMD_RD_FLASH: begin
        next_data_out = pin_s2.bs_a ? f_rdata[15:8] : f_rdata[7:0];
      end
      CMD_RD_EE: begin
        if (!pin_s2.bs_a) begin
          next_data_out = e_rdata;
        end
      end
      CMD_RD_FUSE: begin
        case ({pin_s2.bs_b, pin_s2.bs_a})
          2'h0: next_data_out = fuse_lo;
          2'h3: next_data_out = fuse_hi;
          2'h2: next_data_out = fuse_ext;
          default: next_data_out = lock;
        endcase
      end
      CMD_RD_SIG: begin
        if (pin_s2.bs_a) begin
          next_data_out = (addr_lo == 8'h00) ? CAL_BYTE : BLANK;
        end else if (addr_lo <= SIG_LAST) begin
          case (addr_lo[1:0])
            2'h0: next_data_out = SIG_BYTE0;
            2'h1: next_data_out = SIG_BYTE1;
            default: next_data_out = SIG_BYTE2;
          endcase
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= 8'hff;
      data_oe  <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe  <= next_data_oe;
    end
  end
endmodule : ppp_port

// file: verif/ppp_port_monitor.sv
// checker on the programming port pins
`timescale 1ns/1ns
module ppp_port_monitor (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       byte_sel_a,
  input wire logic       byte_sel_b,
  input wire logic       load_strobe,
  input wire logic       buffer_latch_pulse,
  input wire logic       write_strobe_b,
  input wire logic       out_enable_b,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       ready_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // erase is the longest busy spell; anything past this is a hang
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  always_comb next_busy_cnt = ready_flag ? 16'h0000 : busy_cnt + 16'h0001;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) busy_cnt <= 16'h0000;
    else busy_cnt <= next_busy_cnt;
  end

  property p_oe_off; out_enable_b [*5] |-> !data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven with oe high");
  property p_oe_on; (!out_enable_b) [*5] |-> data_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven with oe low");
  property p_oe_rise; $rose(data_oe) |-> !out_enable_b && !$past(out_enable_b, 2); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("driver on without oe");
  property p_oe_fall; $fell(data_oe) |-> out_enable_b && $past(out_enable_b, 2); endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("driver off while oe low");
  property p_busy_cause; $fell(ready_flag) |-> !$past(write_strobe_b, 2); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
  property p_busy_min; $fell(ready_flag) |-> !ready_flag [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy spell too short");
  property p_busy_max; busy_cnt < 16'h8100; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy never ends");
  property p_ready_back; $rose(ready_flag) |-> $past(busy_cnt) >= 16'h0008; endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready came back early");
  property p_hold;
    ($stable(byte_sel_a) && $stable(byte_sel_b) && $stable(out_enable_b) && !load_strobe
     && !buffer_latch_pulse && write_strobe_b && ready_flag) [*8] |=> $stable(data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved while idle");

  c_erase: cover property (busy_cnt == 16'h7f00);
  c_read: cover property ($rose(data_oe));
  c_prog: cover property ($fell(ready_flag));
endmodule : ppp_port_monitor

bind ppp_port ppp_port_monitor ppp_port_monitor_inst (.core_clk(core_clk), .rst_b(rst_b),
  .byte_sel_a(byte_sel_a), .byte_sel_b(byte_sel_b), .load_strobe(load_strobe),
  .buffer_latch_pulse(buffer_latch_pulse), .write_strobe_b(write_strobe_b),
  .out_enable_b(out_enable_b), .data_out(data_out), .data_oe(data_oe),
  .ready_flag(ready_flag));

// file: verif/ppp_programmer.sv
// external programmer model: drives strobes, selects and the data bus
`timescale 1ns/1ns
module ppp_programmer
  import ppp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       ready_flag,
  input  wire logic [7:0] data_bus,
  output ppp_pins_t       pins
);
  initial pins = {4'hc, 4'h3, 8'hff};
  // a released bus toggles so a stale value never reads as valid
  always @(negedge core_clk) if (!pins.oe_b) pins.data <= ~pins.data;

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic load(input logic [1:0] act, input logic a, input logic [7:0] d);
    {pins.act_hi, pins.act_lo} = act;
    pins.bs_a = a;
    pins.data = d;
    cyc(3);
    pins.load = 1'b1;
    cyc(4);
    pins.load = 1'b0;
    cyc(4);
  endtask : load
  task automatic latch();
    pins.bs_a = 1'b1;
    cyc(3);
    pins.latch = 1'b1;
    cyc(4);
    pins.latch = 1'b0;
    cyc(4);
  endtask : latch
  // returns busy cycles seen; an ignored write gives 0
  task automatic write(input logic b, input logic a, output int n);
    {pins.bs_b, pins.bs_a} = {b, a};
    n = 0;
    cyc(3);
    pins.wr_b = 1'b0;
    cyc(4);
    pins.wr_b = 1'b1;
    while (!ready_flag && n < 40000) begin
      cyc(1);
      n++;
    end
    cyc(3);
  endtask : write
  task automatic read(input logic b, input logic a, output logic [7:0] got);
    {pins.bs_b, pins.bs_a} = {b, a};
    pins.oe_b = 1'b0;
    cyc(8);
    got = data_bus;
    pins.oe_b = 1'b1;
    cyc(5);
  endtask : read
endmodule : ppp_programmer

// file: verif/ppp_port_tb_top.sv
// self-checking bench for the parallel programming port
`timescale 1ns/1ns
module ppp_port_tb_top
  import ppp_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       rst_b    = 1'b0;
  ppp_pins_t  pins;
  logic [7:0] bus;
  logic [7:0] data_out;
  logic       data_oe;
  logic       ready_flag;
  logic [7:0] got;
  int         err_count = 0;
  int         n_checks  = 0;
  int         cycles    = 0;
  int         w;

  // the device owns the wire only while its driver is enabled
  assign bus = data_oe ? data_out : pins.data;
  always #10 core_clk = ~core_clk;

  ppp_port ppp_port_inst (.core_clk(core_clk), .rst_b(rst_b),
    .strobe_action_sel_hi(pins.act_hi), .strobe_action_sel_lo(pins.act_lo),
    .byte_sel_a(pins.bs_a), .byte_sel_b(pins.bs_b), .load_strobe(pins.load),
    .buffer_latch_pulse(pins.latch), .write_strobe_b(pins.wr_b), .out_enable_b(pins.oe_b),
    .data_in(bus), .data_out(data_out), .data_oe(data_oe), .ready_flag(ready_flag));
  ppp_programmer ppp_programmer_inst (.core_clk(core_clk), .ready_flag(ready_flag),
    .data_bus(bus), .pins(pins));

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic busy(input int lo, input int hi);
    chk({7'h00, (w >= lo && w <= hi)}, 8'h01);
  endtask : busy
  task automatic cmd(input logic [7:0] c);
    ppp_programmer_inst.load(ACT_CMD, 1'b0, c);
  endtask : cmd
  task automatic adr(input logic a, input logic [7:0] d);
    ppp_programmer_inst.load(ACT_ADDR, a, d);
  endtask : adr
  task automatic dat(input logic a, input logic [7:0] d);
    ppp_programmer_inst.load(ACT_DATA, a, d);
  endtask : dat
  task automatic wr(input logic b, input logic a);
    ppp_programmer_inst.write(b, a, w);
  endtask : wr
  task automatic rd(input logic b, input logic a, input logic [7:0] e);
    ppp_programmer_inst.read(b, a, got);
    chk(got, e);
  endtask : rd

  task automatic t_reset();
    chk({7'h00, ready_flag}, 8'h01);
    cmd(CMD_RD_FUSE);
    rd(1'b0, 1'b0, FUSE_LO_RST);
    rd(1'b0, 1'b1, LOCK_RST);
  endtask : t_reset
  task automatic t_erase(input logic [7:0] ee_exp);
    cmd(CMD_ERASE);
    wr(1'b0, 1'b0);
    busy(32700, 32800);
    cmd(CMD_RD_FLASH);
    adr(1'b1, 8'h01);
    adr(1'b0, 8'h85);
    rd(1'b0, 1'b1, BLANK);
    cmd(CMD_RD_EE);
    adr(1'b1, 8'h00);
    adr(1'b0, 8'h0a);
    rd(1'b0, 1'b0, ee_exp);
    cmd(CMD_RD_FUSE);
    rd(1'b0, 1'b1, LOCK_RST);
  endtask : t_erase
  task automatic t_flash();
    cmd(CMD_WR_FLASH);
    adr(1'b0, 8'h85);
    dat(1'b0, 8'h34);
    dat(1'b1, 8'h12);
    ppp_programmer_inst.latch();
    adr(1'b1, 8'h01);
    wr(1'b0, 1'b0);
    busy(100, 140);
    cmd(CMD_NOP);
    wr(1'b0, 1'b0);
    busy(0, 0);
    cmd(CMD_RD_FLASH);
    rd(1'b0, 1'b0, 8'h34);
    rd(1'b0, 1'b1, 8'h12);
    adr(1'b0, 8'h05);
    rd(1'b0, 1'b0, BLANK);
  endtask : t_flash
  task automatic t_eeprom();
    cmd(CMD_WR_EE);
    adr(1'b1, 8'h00);
    adr(1'b0, 8'h0a);
    dat(1'b0, 8'h5c);
    ppp_programmer_inst.latch();
    wr(1'b0, 1'b1);
    busy(0, 0);
    wr(1'b0, 1'b0);
    busy(3, 12);
    cmd(CMD_RD_EE);
    rd(1'b0, 1'b0, 8'h5c);
  endtask : t_eeprom
  task automatic t_fuse();
    logic [7:0] v [3] = '{8'ha5, 8'hf7, 8'h0e};
    logic [1:0] ws [3] = '{2'h0, 2'h1, 2'h2};
    logic [1:0] rs [3] = '{2'h0, 2'h3, 2'h2};
    cmd(CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      dat(1'b0, v[i]);
      wr(ws[i][1], ws[i][0]);
      busy(0, 0);
    end
    cmd(CMD_RD_FUSE);
    for (int i = 0; i < 3; i++) rd(rs[i][1], rs[i][0], v[i]);
  endtask : t_fuse
  task automatic t_lock();
    cmd(CMD_WR_LOCK);
    dat(1'b0, 8'hfc);
    wr(1'b0, 1'b0);
    dat(1'b0, 8'hc3);
    wr(1'b0, 1'b0);
    cmd(CMD_RD_FUSE);
    rd(1'b0, 1'b1, 8'hfc);
  endtask : t_lock
  task automatic t_sig();
    logic [7:0] s [3] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
    cmd(CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      adr(1'b0, 8'(i));
      rd(1'b0, 1'b0, s[i]);
    end
    // past the last signature address nothing is decoded
    adr(1'b0, 8'h03);
    rd(1'b0, 1'b0, BLANK);
    adr(1'b0, 8'h00);
    rd(1'b0, 1'b1, CAL_BYTE);
  endtask : t_sig

  // ceiling covers two full erases plus every short scenario
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    t_reset();
    t_erase(BLANK);
    t_flash();
    t_eeprom();
    t_fuse();
    t_lock();
    t_sig();
    t_erase(8'h5c);
    print_verdict();
  end
endmodule : ppp_port_tb_top
